// file: design/iosp_consts.svh
`ifndef IOSP_CONSTS_SVH
`define IOSP_CONSTS_SVH

`define IOSP_ADDR_W         16
`define IOSP_DDR_ADDR       16'hffbd
`define IOSP_ANALOG_ADDR    16'hffbe
`define IOSP_LATCH_ADDR     16'hffbf
`define IOSP_DDR_RST_EXP    8'h81
`define IOSP_DDR_RST_SGL    8'h80
`define IOSP_LATCH_RST      8'h80
`define IOSP_RSVD_BIT       7
`define IOSP_CLK_PIN        0
`define IOSP_STB_PIN        1
`define IOSP_TX_PIN         4
`define IOSP_RX_PIN         5
`define IOSP_SCK_PIN        6

`endif

// file: design/iosp_pkg.sv
package iosp_pkg;
  // serial unit's use of pins 4..6
  typedef struct packed {
    logic tx_en;
    logic tx_data;
    logic rx_en;
    logic sck_en;
    logic sck_out_en;
    logic sck_out;
  } iosp_ser_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } iosp_bus_s;
endpackage

// file: design/iosp_sync.sv
`timescale 1ns/10ps
`default_nettype none
// three-stage pin synchroniser; output changes once stages two and three agree
module iosp_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] pin_i,
  output var  logic [W-1:0] lvl_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          lvl_o[g] <= 1'b0;
        end else if (s2_q[g] == s3_q[g]) begin
          lvl_o[g] <= s3_q[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: design/iosp_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "iosp_consts.svh"
module iosp_top
  import iosp_pkg::*;
#(
  parameter int PW = 7
) (
  input  wire logic       MCLK_I,
  input  wire logic       RST_B_I,
  input  wire logic       EXPANDED_I,
  input  wire logic       DUAL_RAM_SLAVE_ENABLE_I,
  input  wire logic       HW_STANDBY_I,
  input  wire logic       SW_STANDBY_I,
  input  wire iosp_bus_s  BUS_I,
  output var  logic [7:0] RDATA_O,
  input  wire logic [7:0] ANALOG_PIN_I,
  output var  logic [7:0] ANALOG_CHANNEL_O,
  input  wire iosp_ser_s  SER_I,
  input  wire logic       SYNC_CLK_I,
  input  wire logic       IO_STROBE_I,
  input  wire logic [PW-1:0] PORT_B_PIN_I,
  output var  logic [PW-1:0] PORT_B_PIN_O,
  output var  logic [PW-1:0] PORT_B_OE_B_O,
  output var  logic [PW-1:0] PORT_B_PULLUP_O,
  output var  logic [3:0] REG_SELECT_O,
  output var  logic       CLOCKED_SERIAL_RX_O,
  output var  logic       CLOCKED_SERIAL_CLOCK_O,
  output var  logic [2:0] EXT_INTERRUPT_O
);
  logic [PW-1:0] dir_q;
  logic [PW-1:0] latch_q;
  logic [PW-1:0] pin_lvl;
  logic [7:0]    ana_lvl;
  logic          mode_exp_q;
  logic          strap_done_q;
  logic          slave;
  logic [PW-1:0] drive_en;
  logic [PW-1:0] drive_val;
  logic [PW-1:0] alt_out;
  logic [PW-1:0] pu_d;
  logic [PW-1:0] pin_rd;
  logic          tx_act;
  logic          rx_act;
  logic          sck_act;
  logic [7:0]    rdata_d;
  logic [7:0]    ddr_rst;

  iosp_sync #(.W(PW)) u_sync_b (
    .clk_i   (MCLK_I),
    .rst_b_i (RST_B_I),
    .pin_i   (PORT_B_PIN_I),
    .lvl_o   (pin_lvl)
  );

  iosp_sync #(.W(8)) u_sync_a (
    .clk_i   (MCLK_I),
    .rst_b_i (RST_B_I),
    .pin_i   (ANALOG_PIN_I),
    .lvl_o   (ana_lvl)
  );

  // mode strap caught after reset release
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      strap_done_q <= 1'b0;
      mode_exp_q   <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      mode_exp_q   <= EXPANDED_I;
    end
  end

  assign slave = !mode_exp_q && DUAL_RAM_SLAVE_ENABLE_I;
  assign ddr_rst = mode_exp_q ? `IOSP_DDR_RST_EXP : `IOSP_DDR_RST_SGL;
  // serial unit released in software standby
  assign tx_act  = SER_I.tx_en && !SW_STANDBY_I;
  assign rx_act  = SER_I.rx_en && !SW_STANDBY_I;
  assign sck_act = SER_I.sck_en && !SW_STANDBY_I;

  // direction register
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      dir_q <= '0;
    end else if (!strap_done_q) begin
      dir_q[`IOSP_CLK_PIN] <= EXPANDED_I;
    end else if (HW_STANDBY_I) begin
      dir_q <= ddr_rst[PW-1:0];
    end else if (BUS_I.wr && BUS_I.addr == `IOSP_DDR_ADDR) begin
      dir_q <= BUS_I.wdata[PW-1:0];
    end
  end

  // output latch
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      latch_q <= '0;
    end else if (HW_STANDBY_I) begin
      latch_q <= '0;
    end else if (BUS_I.wr && BUS_I.addr == `IOSP_LATCH_ADDR) begin
      latch_q <= BUS_I.wdata[PW-1:0];
    end
  end

  // per-pin drive selection
  always_comb begin
    alt_out   = latch_q;
    drive_en  = dir_q;
    drive_val = latch_q;
    pu_d      = ~dir_q & latch_q;
    if (mode_exp_q) begin
      alt_out[`IOSP_CLK_PIN] = SW_STANDBY_I ? 1'b0 : SYNC_CLK_I;
      alt_out[`IOSP_STB_PIN] = IO_STROBE_I;
      drive_val[`IOSP_CLK_PIN] = alt_out[`IOSP_CLK_PIN];
      drive_val[`IOSP_STB_PIN] = alt_out[`IOSP_STB_PIN];
    end
    if (slave) begin
      drive_en[3:0] = 4'h0;
    end
    if (tx_act) begin
      drive_en[`IOSP_TX_PIN]  = 1'b1;
      drive_val[`IOSP_TX_PIN] = SER_I.tx_data;
      pu_d[`IOSP_TX_PIN]      = 1'b0;
    end
    if (rx_act) begin
      drive_en[`IOSP_RX_PIN] = 1'b0;
    end
    if (sck_act) begin
      drive_en[`IOSP_SCK_PIN]  = SER_I.sck_out_en;
      drive_val[`IOSP_SCK_PIN] = SER_I.sck_out;
    end
    if (HW_STANDBY_I) begin
      drive_en = '0;
      pu_d     = '0;
    end
  end

  // pin drivers, all registered
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PORT_B_PIN_O    <= '0;
      PORT_B_OE_B_O   <= '1;
      PORT_B_PULLUP_O <= '0;
    end else begin
      PORT_B_PIN_O    <= drive_val;
      PORT_B_OE_B_O   <= ~drive_en;
      PORT_B_PULLUP_O <= pu_d;
    end
  end

  // alternate-function inputs see synchronised pin levels; interrupt inputs see the read value (latch on output pins)
  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      REG_SELECT_O           <= 4'h0;
      CLOCKED_SERIAL_RX_O    <= 1'b0;
      CLOCKED_SERIAL_CLOCK_O <= 1'b0;
      EXT_INTERRUPT_O        <= 3'h0;
      ANALOG_CHANNEL_O       <= 8'h00;
    end else begin
      REG_SELECT_O           <= pin_lvl[3:0];
      CLOCKED_SERIAL_RX_O    <= pin_lvl[`IOSP_RX_PIN];
      CLOCKED_SERIAL_CLOCK_O <= pin_lvl[`IOSP_SCK_PIN];
      EXT_INTERRUPT_O        <= pin_rd[6:4];
      ANALOG_CHANNEL_O       <= ana_lvl;
    end
  end

  // read path: outputs give latch, inputs give live level
  genvar g;
  generate
    for (g = 0; g < PW; g++) begin : g_rd
      assign pin_rd[g] = dir_q[g] ? latch_q[g] : pin_lvl[g];
    end
  endgenerate

  always_comb begin
    rdata_d = 8'h00;
    if (BUS_I.rd) begin
      case (BUS_I.addr)
        `IOSP_ANALOG_ADDR: rdata_d = ana_lvl;
        `IOSP_LATCH_ADDR:  rdata_d = {1'b1, pin_rd};
        `IOSP_DDR_ADDR:    rdata_d = 8'hff;
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RDATA_O <= 8'h00;
    end else begin
      RDATA_O <= rdata_d;
    end
  end

  AST_HWSTBY_HIZ: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    HW_STANDBY_I |=> (PORT_B_OE_B_O == '1) && (PORT_B_PULLUP_O == '0))
    else $error("pins not released in hardware standby");
  AST_TX_DRIVE: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (SER_I.tx_en && !SW_STANDBY_I && !HW_STANDBY_I) |=>
      !PORT_B_OE_B_O[4] && !PORT_B_PULLUP_O[4])
    else $error("transmit pin not driven");
  AST_BIT7_READ: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (BUS_I.rd && BUS_I.addr == `IOSP_LATCH_ADDR) |=> RDATA_O[7])
    else $error("reserved bit not read as one");
  AST_ANALOG_READ: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (BUS_I.rd && BUS_I.addr == `IOSP_ANALOG_ADDR) |=> RDATA_O == $past(ana_lvl))
    else $error("analog read mismatch");
  AST_DIR_OUT: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (dir_q[2] && !slave && !HW_STANDBY_I) |=> !PORT_B_OE_B_O[2])
    else $error("pin 2 not driven");
  AST_SLAVE_IN: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (slave && !HW_STANDBY_I) |=> PORT_B_OE_B_O[3:0] == 4'hf)
    else $error("select pin driven in slave mode");
  AST_PULLUP: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (!HW_STANDBY_I && !dir_q[5] && latch_q[5]) |=> PORT_B_PULLUP_O[5])
    else $error("pull-up not enabled");
  AST_SWSTBY_CLK: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (SW_STANDBY_I && mode_exp_q) |=> !PORT_B_PIN_O[0])
    else $error("sync clock not low in software standby");

  AST_STRAP_DIR0: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    $rose(strap_done_q) |->
      dir_q[0] == mode_exp_q)
    else $error("direction bit 0 not set from mode strap");

  AST_LATCH_WRITE: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (BUS_I.wr && BUS_I.addr == `IOSP_LATCH_ADDR && !HW_STANDBY_I) |=>
      {1'b0, latch_q} == ($past(BUS_I.wdata) & 8'h7f))
    else $error("latch write not taken");

  AST_DIR_WRITE: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (BUS_I.wr && BUS_I.addr == `IOSP_DDR_ADDR && strap_done_q && !HW_STANDBY_I) |=>
      {1'b0, dir_q} == ($past(BUS_I.wdata) & 8'h7f))
    else $error("direction write not taken");

  AST_DDR_READ: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (BUS_I.rd && BUS_I.addr == `IOSP_DDR_ADDR) |=>
      RDATA_O == 8'hff)
    else $error("direction read not all ones");

  AST_IDLE_RDATA: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    !BUS_I.rd |=>
      RDATA_O == 8'h00)
    else $error("read data not cleared when idle");

  AST_LATCH_READ: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (BUS_I.rd && BUS_I.addr == `IOSP_LATCH_ADDR) |=>
      RDATA_O[6:0] == $past(pin_rd))
    else $error("latch read value mismatch");

  AST_PIN_DRIVE: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (dir_q[3] && !slave && !HW_STANDBY_I) |=>
      PORT_B_PIN_O[3] == $past(latch_q[3]))
    else $error("pin 3 not driving latch");

  AST_EXP_CLK: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (mode_exp_q && !SW_STANDBY_I && !HW_STANDBY_I) |=>
      PORT_B_PIN_O[0] == $past(SYNC_CLK_I) && PORT_B_OE_B_O[0] == !$past(dir_q[0]))
    else $error("sync clock pin mismatch");

  AST_EXP_STB: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    mode_exp_q |=>
      PORT_B_PIN_O[1] == $past(IO_STROBE_I))
    else $error("io strobe pin mismatch");

  AST_REG_SEL: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    slave |=>
      REG_SELECT_O == $past(pin_lvl[3:0]))
    else $error("register select input mismatch");

  AST_GPIO_SGL: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (!mode_exp_q && !DUAL_RAM_SLAVE_ENABLE_I && dir_q[0] && !HW_STANDBY_I) |=>
      !PORT_B_OE_B_O[0] && PORT_B_PIN_O[0] == $past(latch_q[0]))
    else $error("pin 0 not general purpose output");

  AST_TX_DATA: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (tx_act && !HW_STANDBY_I) |=>
      PORT_B_PIN_O[4] == $past(SER_I.tx_data))
    else $error("transmit data mismatch");

  AST_RX_IN: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (rx_act && !HW_STANDBY_I) |=>
      PORT_B_OE_B_O[5])
    else $error("receive pin driven");

  AST_SCK_DRV: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (sck_act && !HW_STANDBY_I) |=>
      PORT_B_OE_B_O[6] == !$past(SER_I.sck_out_en))
    else $error("serial clock direction mismatch");

  AST_SWSTBY_PORT: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    (SW_STANDBY_I && !HW_STANDBY_I) |=>
      PORT_B_OE_B_O[6:4] == ~$past(dir_q[6:4]))
    else $error("serial pins not back to port use");

  AST_ANALOG_CH: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    1'b1 |=>
      ANALOG_CHANNEL_O == $past(ana_lvl))
    else $error("analog channel mismatch");

  AST_IRQ_LVL: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
    1'b1 |=>
      EXT_INTERRUPT_O == $past(pin_rd[6:4]))
    else $error("interrupt input mismatch");

endmodule
`default_nettype wire

// file: tb/iosp_pins.sv
`timescale 1ns/10ps
`default_nettype none
// board side of port B: resolves each pin from all of its drivers
module iosp_pins (
  input  wire logic       clk_i,
  input  wire logic [6:0] drv_i,
  input  wire logic [6:0] oe_b_i,
  input  wire logic [6:0] pu_i,
  input  wire logic [6:0] ext_en_i,
  input  wire logic [6:0] ext_i,
  output var  logic [6:0] lvl_o
);
  logic [6:0] flt_q = 7'h00;
  // an undriven line without pull-up wanders every cycle
  always_ff @(posedge clk_i) flt_q <= ~flt_q;
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (!oe_b_i[i]) lvl_o[i] = drv_i[i];
      else if (ext_en_i[i]) lvl_o[i] = ext_i[i];
      else if (pu_i[i]) lvl_o[i] = 1'b1;
      else lvl_o[i] = flt_q[i];
    end
  end
endmodule
`default_nettype wire

// file: tb/iosp_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module iosp_top_tb import iosp_pkg::*;;
  logic       clk, rst_b, expd, dual_ram_slave_enable, hws, sws, sclk, stb, rx, sck;
  iosp_bus_s  bus;
  iosp_ser_s  ser;
  logic [7:0] ana, rdata, ana_ch;
  logic [6:0] lvl, pin_o, oe, pu, xen, xv;
  logic [3:0] rs;
  logic [2:0] irq;
  int         num_errors, comparisons;
  iosp_top u_dut (.MCLK_I(clk), .RST_B_I(rst_b), .EXPANDED_I(expd),
    .DUAL_RAM_SLAVE_ENABLE_I(dual_ram_slave_enable), .HW_STANDBY_I(hws),
    .SW_STANDBY_I(sws), .BUS_I(bus), .RDATA_O(rdata),
    .ANALOG_PIN_I(ana), .ANALOG_CHANNEL_O(ana_ch), .SER_I(ser),
    .SYNC_CLK_I(sclk), .IO_STROBE_I(stb), .PORT_B_PIN_I(lvl),
    .PORT_B_PIN_O(pin_o), .PORT_B_OE_B_O(oe), .PORT_B_PULLUP_O(pu),
    .REG_SELECT_O(rs), .CLOCKED_SERIAL_RX_O(rx),
    .CLOCKED_SERIAL_CLOCK_O(sck), .EXT_INTERRUPT_O(irq));
  iosp_pins u_pins (.clk_i(clk), .drv_i(pin_o), .oe_b_i(oe), .pu_i(pu),
    .ext_en_i(xen), .ext_i(xv), .lvl_o(lvl));
  always #25 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus.wr = 1'b1;
    bus.addr = a;
    bus.wdata = d;
    cyc(1);
    bus.wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, string n);
    bus.rd = 1'b1;
    bus.addr = a;
    cyc(1);
    bus.rd = 1'b0;
    chk(n, e, rdata);
    cyc(1);
  endtask
  task automatic rst(input logic m);
    expd = m;
    rst_b = 1'b0;
    cyc(16);
    rst_b = 1'b1;
    cyc(8);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_reset;
    chk("oe", 8'h7f, {1'b0, oe});
    chk("pu", 8'h00, {1'b0, pu});
    rd(16'hffbd, 8'hff, "dir");
    rd(16'hffbc, 8'h00, "unmapped");
    rd(16'hffbf, 8'haa, "latch");
    $display("reset test done");
  endtask
  task automatic t_analog;
    ana = 8'ha5;
    cyc(8);
    rd(16'hffbe, 8'ha5, "analog");
    chk("chan", 8'ha5, ana_ch);
    ana = 8'h3c;
    cyc(8);
    rd(16'hffbe, 8'h3c, "analog");
    $display("analog test done");
  endtask
  task automatic t_gpio;
    xen = 7'h70;
    xv = 7'h50;
    wr(16'hffbf, 8'h0a);
    wr(16'hffbd, 8'h0f);
    cyc(8);
    chk("oe", 8'h70, {1'b0, oe});
    chk("pin", 8'h0a, {4'h0, pin_o[3:0]});
    rd(16'hffbf, 8'hda, "latch");
    wr(16'hffbf, 8'h7a);
    cyc(3);
    chk("pu", 8'h70, {1'b0, pu});
    rd(16'hffbf, 8'hda, "latch");
    chk("irq", 8'h05, {5'h00, irq});
    $display("gpio test done");
  endtask
  task automatic t_serial;
    wr(16'hffbf, 8'h3a);
    xen = 7'h60;
    xv = 7'h20;
    ser = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    cyc(8);
    chk("rx", 8'h01, {7'h00, rx});
    chk("sck", 8'h00, {7'h00, sck});
    ser = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    xen = 7'h20;
    cyc(3);
    chk("oe", 8'h20, {1'b0, oe});
    chk("pu", 8'h20, {1'b0, pu});
    chk("pin", 8'h4a, {1'b0, pin_o & 7'h5f});
    sws = 1'b1;
    cyc(3);
    chk("oe", 8'h70, {1'b0, oe});
    chk("pu", 8'h30, {1'b0, pu});
    sws = 1'b0;
    ser = '0;
    cyc(2);
    $display("serial test done");
  endtask
  task automatic t_slave;
    dual_ram_slave_enable = 1'b1;
    xen = 7'h7f;
    xv = 7'h05;
    cyc(8);
    chk("oe", 8'h7f, {1'b0, oe});
    chk("rs", 8'h05, {4'h0, rs});
    wr(16'hffbd, 8'h00);
    cyc(3);
    chk("pu", 8'h3a, {1'b0, pu});
    dual_ram_slave_enable = 1'b0;
    wr(16'hffbd, 8'h0f);
    hws = 1'b1;
    cyc(3);
    chk("oe", 8'h7f, {1'b0, oe});
    chk("pu", 8'h00, {1'b0, pu});
    hws = 1'b0;
    $display("slave and standby test done");
  endtask
  task automatic t_expanded;
    rst(1'b1);
    chk("oe", 8'h7e, {1'b0, oe});
    chk("pin0", 8'h01, {7'h00, pin_o[0]});
    wr(16'hffbd, 8'h02);
    cyc(3);
    chk("oe", 8'h7d, {1'b0, oe});
    chk("pin1", 8'h01, {7'h00, pin_o[1]});
    stb = 1'b0;
    cyc(3);
    chk("pin1", 8'h00, {7'h00, pin_o[1]});
    wr(16'hffbd, 8'h03);
    sclk = 1'b0;
    cyc(3);
    chk("pin0", 8'h00, {7'h00, pin_o[0]});
    sclk = 1'b1;
    sws = 1'b1;
    cyc(3);
    chk("pin0", 8'h00, {7'h00, pin_o[0]});
    $display("expanded test done");
  endtask
  initial begin
    #1ms;
    num_errors++;
    finish_test;
  end
  initial begin
    {clk, rst_b, expd, dual_ram_slave_enable, hws, sws, sclk, stb} = 8'h03;
    bus = '0;
    ser = '0;
    ana = 8'h00;
    xen = 7'h7f;
    xv = 7'h2a;
    num_errors = 0;
    comparisons = 0;
    cyc(1);
    rst(1'b0);
    t_reset();
    t_analog();
    t_gpio();
    t_serial();
    t_slave();
    t_expanded();
    finish_test;
  end
endmodule
`default_nettype wire
